// ### logic/nbd_alu.sv
// Four-bit arithmetic and logic unit of the nibble core.
// Purely combinational; the caller decides which flags it keeps.
`timescale 1ns/1ns
module nbd_alu import nbd_pkg::*; (
  input wire logic [3:0] a,
  input wire logic [3:0] b,
  input wire logic cin,
  input wire nbd_alu_op_t op,
  output logic [3:0] y,
  output logic cout
);
  logic [4:0] r;

  // Subtraction is a minus b; cout then flags a borrow.
  always_comb begin
    r = {1'b0, a & b};
    unique case (op)
      NBD_ADD: r = {1'b0, a} + {1'b0, b};
      NBD_ADC: r = {1'b0, a} + {1'b0, b} + {4'h0, cin};
      NBD_SUB: r = {1'b0, a} - {1'b0, b};
      NBD_SBC: r = {1'b0, a} - {1'b0, b} - {4'h0, cin};
      NBD_AND: r = {1'b0, a & b};
      NBD_OR: r = {1'b0, a | b};
      NBD_XOR: r = {1'b0, a ^ b};
    endcase
  end

  assign y = r[3:0];
  assign cout = r[4];
endmodule // nbd_alu

// ### logic/nbd_ctx_stack.sv
// Sixteen-level stack of saved core context for call and return.
// Push and pop come from the decoder on the same clock, never together.
`timescale 1ns/1ns
module nbd_ctx_stack import nbd_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic push,
  input wire logic pop,
  input wire nbd_ctx_t din,
  output nbd_ctx_t top
);
  nbd_ctx_t mem [STACK_DEPTH];
  logic [SP_W-1:0] sp_r;

  // The pointer wraps, so a seventeenth call overwrites the oldest entry.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sp_r <= '0;
    end else if (push) begin
      sp_r <= sp_r + 1'b1;
    end else if (pop) begin
      sp_r <= sp_r - 1'b1;
    end
  end

  // Entries carry no reset; only pushed words are ever popped.
  always_ff @(posedge hclk) begin
    if (push) begin
      mem[sp_r] <= din;
    end
  end

  assign top = mem[sp_r - 1'b1];

  a_stack_push_top: assert property (
    @(posedge hclk) disable iff (!hresetn)
    push |=> top == $past(din))
    else $error("pushed context is not on top of the stack");
endmodule // nbd_ctx_stack

// ### logic/nbd_decoder.sv
// Decode and execute logic of a 4-bit core running 16-bit instructions.
// Program ROM is read combinationally through rom_addr/rom_rdata on hclk;
// data RAM and working registers live here. Registers sit on AHB-Lite.
// Functional notes
// - ADD R adds RAM nibble to accumulator only, flags updated, one cycle.
// - ADD write-back form puts the sum in accumulator and RAM nibble.
// - Add-with-carry sums RAM nibble, accumulator and carry into accumulator.
// - Flag-preserving add updates zero flag only, carry unchanged.
// - Subtract computes RAM nibble minus accumulator into accumulator.
// - Subtract-with-borrow computes nibble minus accumulator minus carry.
// - Increment or decrement writes nibble plus or minus one to both.
// - AND, OR, XOR with RAM update zero flag, never carry.
// - Jump loads PC with ROM page times 800H plus 11-bit field.
// - Accumulator-bit jumps replace PC bits 10..0 when that bit is set.
// - Zero, nonzero, carry, no-carry jumps replace PC bits 10..0 on condition.
// - Decrement-and-skip writes nibble minus one, skips on zero or nonzero.
// - Bit-test skips add two to PC when the RAM bit is set.
// - Call pushes PC plus one and all context, then jumps far.
// - Plain return restores only the program counter.
// - Masked return restores PC and the context groups whose bits are set.
// - Mask bits: table, bank, work page, ROM page, page, accumulator, carry.
// - Indirect load reads bank, page and pointer address in two cycles.
// - Indirect store writes the same address form in two cycles.
// - Table look-up reads ROM at table address over four, two cycles.
// - Register-to-RAM moves with accumulator copy set zero; plain moves none.
// - Immediate move writes bits 10..7 into RAM nibble, no flags.
// - RAM-to-accumulator move sets zero flag; accumulator-to-RAM sets none.
// - Table nibble writes select register by opcode bit and low bit 7.
//
// Local design decisions: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ns
module nbd_decoder import nbd_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [PC_W-1:0] rom_addr,
  input wire logic [15:0] rom_rdata
);
  logic [3:0] dram [DRAM_DEPTH];
  logic [3:0] wreg [WREG_DEPTH];
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [3:0] acc_r, acc_nxt, dbl_r, dbl_nxt, wrp_r, wrp_nxt;
  logic [3:0] rom_page_reg_r, rom_page_reg_nxt;
  logic [2:0] page_r, page_nxt;
  logic cf_r, cf_nxt, zf_r, zf_nxt, dbh_r, dbh_nxt, run_r;
  logic [15:0] tab_r, tab_nxt, ir_r;
  nbd_state_t state_r, state_nxt;
  nbd_ahb_ap_t ap_r;
  logic [31:0] hrdata_r;
  logic dm_we, wr_we, push, pop;
  logic [DADDR_W-1:0] dm_addr;
  logic [3:0] dm_wd, wr_wd;
  logic [7:0] wr_idx;
  nbd_alu_op_t grp_op;
  nbd_ctx_t stk_top;

  // Working registers are 16 pages of 16 nibbles.
  function automatic logic [7:0] wr_at(input logic [3:0] pg,
                                       input logic [3:0] n);
    return {pg, n};
  endfunction

  // Instruction and its fields; the second cycle replays the held word.
  wire in_second = state_r == NBD_SECOND;
  wire [15:0] ins = in_second ? ir_r : rom_rdata;
  wire [7:0] hb = ins[15:8];
  wire [3:0] tn = ins[15:12];
  wire b11 = ins[11];
  wire b7 = ins[7];
  wire step = ce & run_r;
  wire exec = step & ~in_second;
  wire second = step & in_second;

  // Operand addressing.
  wire [DADDR_W-1:0] dir_addr = {dbh_r, dbl_r, ins[6:0]};
  wire [3:0] rd = dram[dir_addr];
  wire [3:0] wr_imm = wreg[wr_at(wrp_r, ins[3:0])];
  wire [7:0] mv_idx = wr_at(wrp_r, ins[10:7]);
  wire [3:0] wr_mv = wreg[mv_idx];
  wire [3:0] ptr = wreg[wr_at(wrp_r, ins[3:0])];
  wire [DADDR_W-1:0] ind_addr = {dbh_r, dbl_r, page_r, ptr};
  wire [3:0] tbl_nib = rom_rdata[{tab_r[1:0], 2'b00} +: 4];

  // Opcode decode.
  wire is_alu = hb[7:6] == HB_ALU_GRP & hb[3];
  wire alu_imm = hb[2];
  wire alu_wb = hb[0];
  wire keep_cf = hb[5];
  wire is_incdec = hb == HB_INCDEC;
  wire is_dsk = hb == HB_DSK;
  wire is_skb = hb[7:1] == HB_SKB;
  wire is_rtn = hb == HB_RTN;
  wire is_jmp = tn == TN_JMP & ~b11;
  wire is_call = tn == TN_CALL & ~b11;
  wire is_jb = tn[3:2] == TN_JB & ~b11;
  wire is_jcond = tn[3:2] == TN_JCOND & ~b11;
  wire is_movi = tn == TN_MOVI & b11;
  wire is_ldi = tn == TN_LDI & b11;
  wire is_sti = tn == TN_STI & b11;
  wire is_mvwr = tn == TN_MVWR & b11;
  wire is_mvrw = tn == TN_MVRW & b11;
  wire is_movaw = tn == TN_MOVAW & b11;
  wire is_movar_w = tn == TN_MOVAR & b11;
  wire is_movra = hb == HB_MOVRA & b7;
  wire is_movar = hb == HB_MOVAR & b7;
  wire is_tabw = (hb == HB_TABLO) | (hb == HB_TABHI);
  wire is_table_lookup = hb == HB_TABLE_LOOKUP & ~b7;
  wire two_cyc = is_ldi | is_sti | is_table_lookup;

  // Group opcode bits 5, 4 and 1 select the operation.
  always_comb begin
    unique case ({hb[5:4], hb[1]})
      3'b000: grp_op = NBD_ADC;
      3'b001: grp_op = NBD_SBC;
      3'b010: grp_op = NBD_ADD;
      3'b011: grp_op = NBD_SUB;
      3'b100: grp_op = NBD_ADD;
      3'b101: grp_op = NBD_AND;
      3'b110: grp_op = NBD_XOR;
      3'b111: grp_op = NBD_OR;
    endcase
  end

  // ALU operands: RAM form uses accumulator, immediate form the constant.
  wire [3:0] alu_a = (is_alu & alu_imm) ? wr_imm : rd;
  wire [3:0] alu_b = ~is_alu ? NIB_ONE : (alu_imm ? ins[7:4] : acc_r);
  wire nbd_alu_op_t alu_sel = is_alu ? grp_op
                            : ((is_dsk | b7) ? NBD_SUB : NBD_ADD);
  logic [3:0] alu_y;
  logic alu_c;
  wire alu_z = alu_y == NIB_RST;

  nbd_alu u_alu (
    .a(alu_a),
    .b(alu_b),
    .cin(cf_r),
    .op(alu_sel),
    .y(alu_y),
    .cout(alu_c)
  );

  // Branch targets and conditions.
  wire [PC_W-1:0] pc_inc = pc_r + 1'b1;
  wire [PC_W-1:0] pc_two = pc_r + 2'd2;
  wire [PC_W-1:0] far_tgt = {rom_page_reg_r, ins[10:0]};
  wire [PC_W-1:0] near_tgt = {pc_r[14:11], ins[10:0]};
  wire jb_hit = acc_r[tn[1:0]];
  wire jc_hit = tn[0] ? (cf_r == tn[1])
                      : ((acc_r == NIB_RST) == tn[1]);
  wire dsk_skip = alu_z ^ b7;
  wire skb_hit = rd[{hb[0], b7}];
  wire [7:0] mask = ins[7:0];
  wire nbd_ctx_t push_ctx = {pc_inc, tab_r, dbl_r, dbh_r, wrp_r, rom_page_reg_r,
                             page_r, acc_r, cf_r};

  nbd_ctx_stack u_stack (
    .hclk(hclk),
    .hresetn(hresetn),
    .push(push),
    .pop(pop),
    .din(push_ctx),
    .top(stk_top)
  );

  // Bus address phase and write decode.
  wire ap_take = hsel & htrans[1] & hready & ce;
  wire ap_wr = ap_r.wr & ce;
  wire wr_ctrl = ap_wr & ap_r.addr == A_CTRL;
  wire wr_ctx = ap_wr & ap_r.addr == A_CTX;
  wire [31:0] ctrl_word = {31'h0, run_r};
  wire [31:0] ctx_word = {16'h0, wrp_r, page_r, dbh_r, dbl_r, rom_page_reg_r};
  wire [31:0] stat_word = {1'b0, pc_r, 9'h0, in_second, zf_r, cf_r, acc_r};
  wire [31:0] tab_word = {16'h0, tab_r};
  wire [7:0] ra = haddr[7:0];
  wire [31:0] rd_word = ra == A_CTRL ? ctrl_word
                      : ra == A_CTX ? ctx_word
                      : ra == A_STAT ? stat_word
                      : ra == A_TAB ? tab_word : 32'h0;

  // Next-state of the core; a bus write to the context register wins.
  always_comb begin
    acc_nxt = acc_r;
    cf_nxt = cf_r;
    zf_nxt = zf_r;
    tab_nxt = tab_r;
    dbl_nxt = dbl_r;
    dbh_nxt = dbh_r;
    wrp_nxt = wrp_r;
    rom_page_reg_nxt = rom_page_reg_r;
    page_nxt = page_r;
    pc_nxt = pc_r;
    state_nxt = state_r;
    dm_we = 1'b0;
    dm_addr = dir_addr;
    dm_wd = alu_y;
    wr_we = 1'b0;
    wr_idx = wr_at(wrp_r, ins[3:0]);
    wr_wd = alu_y;
    push = 1'b0;
    pop = 1'b0;
    if (exec) begin
      pc_nxt = pc_inc;
      if (is_alu) begin
        acc_nxt = alu_y;
        zf_nxt = alu_z;
        if (!keep_cf) begin
          cf_nxt = alu_c;
        end
        if (alu_wb & alu_imm) begin
          wr_we = 1'b1;
        end
        if (alu_wb & ~alu_imm) begin
          dm_we = 1'b1;
        end
      end
      if (is_incdec | is_dsk) begin
        acc_nxt = alu_y;
        zf_nxt = alu_z;
        cf_nxt = alu_c;
        dm_we = 1'b1;
      end
      if ((is_dsk & dsk_skip) | (is_skb & skb_hit)) begin
        pc_nxt = pc_two;
      end
      if (is_jmp | is_call) begin
        pc_nxt = far_tgt;
      end
      push = is_call;
      if ((is_jb & jb_hit) | (is_jcond & jc_hit)) begin
        pc_nxt = near_tgt;
      end
      if (is_rtn) begin
        pop = 1'b1;
        pc_nxt = stk_top.pc;
        if (mask[RM_TAB]) tab_nxt = stk_top.tab;
        if (mask[RM_DB]) begin
          dbl_nxt = stk_top.dbl;
          dbh_nxt = stk_top.dbh;
        end
        if (mask[RM_WRP]) wrp_nxt = stk_top.work_reg_page;
        if (mask[RM_ROM_PAGE_REG]) rom_page_reg_nxt = stk_top.rom_page_reg;
        if (mask[RM_PAGE]) page_nxt = stk_top.page;
        if (mask[RM_ACC]) acc_nxt = stk_top.acc;
        if (mask[RM_CF]) cf_nxt = stk_top.cf;
      end
      if (is_mvwr | is_movaw) begin
        wr_we = 1'b1;
        wr_idx = mv_idx;
        wr_wd = rd;
      end
      if (is_movaw | is_movar) begin
        acc_nxt = rd;
        zf_nxt = rd == NIB_RST;
      end
      if (is_mvrw | is_movar_w) begin
        dm_we = 1'b1;
        dm_wd = wr_mv;
      end
      if (is_movar_w) begin
        acc_nxt = wr_mv;
        zf_nxt = wr_mv == NIB_RST;
      end
      if (is_movi) begin
        dm_we = 1'b1;
        dm_wd = ins[10:7];
      end
      if (is_movra) begin
        dm_we = 1'b1;
        dm_wd = acc_r;
      end
      if (is_tabw) begin
        tab_nxt[{hb[1], b7, 2'b00} +: 4] = rd;
      end
      if (two_cyc) begin
        state_nxt = NBD_SECOND;
      end
    end
    if (second) begin
      state_nxt = NBD_EXEC;
      if (is_ldi) begin
        wr_we = 1'b1;
        wr_idx = mv_idx;
        wr_wd = dram[ind_addr];
      end
      if (is_sti) begin
        dm_we = 1'b1;
        dm_addr = ind_addr;
        dm_wd = wr_mv;
      end
      if (is_table_lookup) begin
        dm_we = 1'b1;
        dm_wd = tbl_nib;
      end
    end
    if (wr_ctx) begin
      rom_page_reg_nxt = hwdata[3:0];
      dbl_nxt = hwdata[7:4];
      dbh_nxt = hwdata[8];
      page_nxt = hwdata[11:9];
      wrp_nxt = hwdata[15:12];
    end
  end

  // ROM port fetches at the PC, or at the table address while looking up.
  assign rom_addr = (in_second & is_table_lookup) ? {1'b0, tab_r[15:2]} : pc_r;

  // Core state registers; everything holds while ce is low.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {pc_r, acc_r, cf_r, zf_r} <= {PC_RST, NIB_RST, 2'b00};
      {tab_r, ir_r} <= '0;
      {dbl_r, dbh_r, wrp_r, rom_page_reg_r, page_r} <= '0;
      state_r <= NBD_EXEC;
    end else if (ce) begin
      {pc_r, acc_r, cf_r, zf_r} <= {pc_nxt, acc_nxt, cf_nxt, zf_nxt};
      tab_r <= tab_nxt;
      {dbl_r, dbh_r, wrp_r} <= {dbl_nxt, dbh_nxt, wrp_nxt};
      {rom_page_reg_r, page_r} <= {rom_page_reg_nxt, page_nxt};
      state_r <= state_nxt;
      if (exec) ir_r <= rom_rdata;
    end
  end

  // Memories carry no reset, which keeps them plain RAM arrays.
  always_ff @(posedge hclk) begin
    if (dm_we) dram[dm_addr] <= dm_wd;
    if (wr_we) wreg[wr_idx] <= wr_wd;
  end

  // Bus slave: read data is captured at the address phase, so a read
  // placed right after a write to the same register returns the old value.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_r <= '0;
      hrdata_r <= '0;
      run_r <= 1'b0;
    end else if (ce) begin
      ap_r <= '{wr: ap_take & hwrite, addr: haddr[7:0]};
      if (ap_take & ~hwrite) hrdata_r <= rd_word;
      if (wr_ctrl) run_r <= hwdata[0];
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = ce;
  assign hresp = 1'b0;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_tbl_start;
    exec && is_table_lookup;
  endsequence

  sequence s_tbl_done;
    second && is_table_lookup;
  endsequence

  a_add_acc_only: assert property (
    exec && is_alu && grp_op == NBD_ADD && !keep_cf && !alu_imm && !alu_wb
    |=> {cf_r, acc_r} == {1'b0, $past(rd)} + {1'b0, $past(acc_r)}
        && dram[$past(dir_addr)] == $past(rd))
    else $error("add did not leave sum in accumulator only");

  a_add_write_back: assert property (
    exec && is_alu && grp_op == NBD_ADD && !keep_cf && !alu_imm && alu_wb
    |=> dram[$past(dir_addr)] == acc_r)
    else $error("write-back add did not store sum to RAM");

  a_sub_order: assert property (
    exec && is_alu && grp_op == NBD_SUB && !alu_imm
    |=> acc_r == 4'($past(rd) - $past(acc_r)))
    else $error("subtract operand order wrong");

  a_keep_carry: assert property (
    exec && is_alu && keep_cf
    |=> $stable(cf_r) && zf_r == (acc_r == NIB_RST))
    else $error("logic or keep-carry add touched carry");

  a_jump_far: assert property (
    exec && is_jmp |=> pc_r == {$past(rom_page_reg_r), $past(ins[10:0])})
    else $error("jump target wrong");

  a_skip_two: assert property (
    exec && is_skb && skb_hit |=> pc_r == $past(pc_r) + 2'd2)
    else $error("bit-test skip did not advance by two");

  a_return_plain: assert property (
    exec && is_rtn && mask == 8'h00
    |=> pc_r == $past(stk_top.pc) && $stable(acc_r) && $stable(tab_r))
    else $error("plain return restored more than the PC");

  a_table_two: assert property (
    s_tbl_start ##1 s_tbl_done
    |=> state_r == NBD_EXEC && dram[$past(dir_addr)] == $past(tbl_nib))
    else $error("table look-up did not finish in the second cycle");
endmodule // nbd_decoder

// ### logic/nbd_pkg.sv
// Shared constants, types and opcode fields of the nibble core decoder.
// Assumes a single 100 MHz clock domain and AHB-Lite register access.
package nbd_pkg;
  localparam int PC_W = 15;
  localparam int DADDR_W = 12;
  localparam int DRAM_DEPTH = 4096;
  localparam int WREG_DEPTH = 256;
  localparam int STACK_DEPTH = 16;
  localparam int SP_W = 4;
  // Upper-byte and top-nibble opcode fields.
  localparam logic [1:0] HB_ALU_GRP = 2'h0;
  localparam logic [7:0] HB_INCDEC = 8'h4a;
  localparam logic [7:0] HB_DSK = 8'h48;
  localparam logic [6:0] HB_SKB = 7'h54;
  localparam logic [7:0] HB_RTN = 8'h01;
  localparam logic [7:0] HB_MOVRA = 8'h59;
  localparam logic [7:0] HB_MOVAR = 8'h4e;
  localparam logic [7:0] HB_TABLO = 8'h8c;
  localparam logic [7:0] HB_TABHI = 8'h8e;
  localparam logic [7:0] HB_TABLE_LOOKUP = 8'h8d;
  localparam logic [3:0] TN_JMP = 4'h7;
  localparam logic [3:0] TN_CALL = 4'h6;
  localparam logic [1:0] TN_JB = 2'h2;
  localparam logic [1:0] TN_JCOND = 2'h3;
  localparam logic [3:0] TN_MOVI = 4'hb;
  localparam logic [3:0] TN_LDI = 4'hc;
  localparam logic [3:0] TN_STI = 4'hd;
  localparam logic [3:0] TN_MVWR = 4'he;
  localparam logic [3:0] TN_MVRW = 4'hf;
  localparam logic [3:0] TN_MOVAW = 4'h6;
  localparam logic [3:0] TN_MOVAR = 4'h7;
  localparam logic [3:0] NIB_ONE = 4'h1;
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  // Return mask bit positions.
  localparam int RM_TAB = 0;
  localparam int RM_DB = 1;
  localparam int RM_WRP = 2;
  localparam int RM_ROM_PAGE_REG = 3;
  localparam int RM_PAGE = 4;
  localparam int RM_ACC = 5;
  localparam int RM_CF = 6;
  // Register byte offsets on the bus.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CTX = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam logic [7:0] A_TAB = 8'h0c;
  typedef enum logic [2:0] {
    NBD_ADD, NBD_ADC, NBD_SUB, NBD_SBC, NBD_AND, NBD_OR, NBD_XOR
  } nbd_alu_op_t;
  typedef enum logic {NBD_EXEC, NBD_SECOND} nbd_state_t;
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [15:0] tab;
    logic [3:0] dbl;
    logic dbh;
    logic [3:0] work_reg_page;
    logic [3:0] rom_page_reg;
    logic [2:0] page;
    logic [3:0] acc;
    logic cf;
  } nbd_ctx_t;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
  } nbd_ahb_ap_t;
endpackage

// ### verif/nbd_rom_model.sv
// Program ROM model standing on the far side of the decoder's fetch port.
// Assumes the bench loads words by hierarchical write; reads are
// combinational of rom_addr, as the fetch contract asks.
`timescale 1ns/1ns
module nbd_rom_model import nbd_pkg::*; (
  input wire logic [PC_W-1:0] rom_addr,
  output logic [15:0] rom_rdata
);
  logic [15:0] mem [0:(1 << PC_W) - 1];

  // Every word starts as zero, an opcode the core simply steps past.
  initial begin
    for (int i = 0; i < (1 << PC_W); i++) begin
      mem[i] = 16'h0000;
    end
  end

  // Fetch answers in the same cycle; a slower ROM would break the core.
  assign rom_rdata = mem[rom_addr];
endmodule // nbd_rom_model

// ### verif/test_nibble_cpu_instruction_decoder.sv
// Self-checking bench of the nibble core decoder, driven over AHB-Lite.
// Assumes nbd_rom_model holds the program; RAM effects are seen via STAT.
`timescale 1ns/1ns
module test_nibble_cpu_instruction_decoder import nbd_pkg::*;;
  logic hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, s;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [PC_W-1:0] rom_addr;
  logic [15:0] rom_rdata;
  logic [47:0] r;
  logic [7:0] msk;
  int error_cnt, num_checks, i, k, p;
  // Row nibbles: opcode(4), ram, acc, carry in, then expected acc, carry,
  // zero, ram after, pc where the program settles.
  logic [47:0] rows [36] = '{
    48'h1800_9801_1098, 48'h1800_8810_1188, 48'h1900_3417_0078,
    48'h0800_7810_1178, 48'h2800_9902_0098, 48'h2800_f110_11f8,
    48'h1a00_350e_1038, 48'h1a00_5312_0058, 48'h0a00_5311_0058,
    48'h0a00_331f_1038, 48'h4a00_f200_1108, 48'h4a80_020f_10f8,
    48'h2a00_ca18_10c8, 48'h3a00_0010_1108, 48'h3800_5500_0158,
    48'h4800_1200_0109, 48'h4800_020f_10f8, 48'h4880_1210_0108,
    48'h4880_3212_0029, 48'ha900_4212_1049, 48'ha800_4212_1048,
    48'ha880_2000_0129, 48'ha980_7303_0078, 48'h800a_0202_0008,
    48'h900a_0202_000a, 48'ha00a_0414_100a, 48'hb00a_0717_1008,
    48'he00a_5000_015a, 48'hc00a_5000_0158, 48'hf00a_5313_105a,
    48'hd00a_5313_1058, 48'h6800_0310_1108, 48'he800_0313_1008,
    48'h4e80_0310_1108, 48'h5980_3010_1108, 48'hbb80_3010_1178};

  nbd_decoder uut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rom_addr(rom_addr),
    .rom_rdata(rom_rdata));
  nbd_rom_model rom (.rom_addr(rom_addr), .rom_rdata(rom_rdata));

  // Free-running 100 MHz bus clock.
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Prints the verdict and ends the run.
  task conclude();
    if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  // Waits for hready at a rising edge, bounded so a dead slave ends the run.
  task rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH hready exp 1 got %b", hreadyout);
      conclude();
    end
  endtask

  // One single word transfer: address phase, then data phase.
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // ROM words change at the falling edge, away from the fetch sample.
  task put(input int a, input logic [15:0] w);
    @(negedge hclk);
    rom.mem[a] = w;
  endtask

  task poll(input int t, output logic [31:0] q);
    int n;
    for (n = 0; n < 60; n++) begin
      xfer(1'b0, A_STAT, 32'h0, q);
      if (q[30:16] === PC_W'(t)) break;
    end
    if (n == 60) begin
      error_cnt++;
      $display("MISMATCH pc exp %h got %h", t, q[30:16]);
      conclude();
    end
  endtask

  // Restarts the core from a fresh reset with a chosen context.
  task go(input logic [31:0] ctx, input int t, output logic [31:0] q);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b1, A_CTX, ctx, q);
    xfer(1'b1, A_CTRL, 32'h1, q);
    poll(t, q);
  endtask

  initial begin
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    error_cnt = 0;
    num_checks = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, read-only status, unmapped hole.
    xfer(1'b0, A_CTRL, 32'h0, s);
    chk("ctrl_rst", 32'h0, s);
    xfer(1'b0, A_TAB, 32'h0, s);
    chk("tab_rst", 32'h0, s & 32'hffff);
    xfer(1'b1, A_CTX, 32'hffff, s);
    xfer(1'b1, A_STAT, 32'hffffffff, s);
    xfer(1'b1, 8'h10, 32'h5, s);
    xfer(1'b0, A_CTX, 32'h0, s);
    chk("ctx_rw", 32'hffff, s & 32'hffff);
    xfer(1'b0, A_STAT, 32'h0, s);
    chk("stat_ro", 32'h0, s & 32'h7fff007f);
    xfer(1'b0, 8'h10, 32'h0, s);
    chk("unmapped", 32'h0, s);
    // Each row seeds RAM, acc and carry, runs one opcode, then reads RAM.
    for (i = 0; i < 36; i++) begin
      r = rows[i];
      put(0, {5'h17, r[31:28], 7'h0});
      put(1, {5'h17, r[27:24], 7'h1});
      put(2, {5'h17, 4'hf, 7'h2});
      put(3, {5'h17, r[23:20], 7'h3});
      put(4, 16'h4e82);
      put(5, 16'h1803);
      put(6, 16'h4e81);
      put(7, r[47:32]);
      for (k = 8; k < 11; k++) put(k, 16'h7000 | 16'(k));
      p = r[3:0];
      go(32'h0, p, s);
      chk("stat", (32'(p) << 16) | {26'h0, r[8], r[12], r[19:16]},
          s & 32'h7fff003f);
      put(p + 1, 16'h7000 | 16'(p + 1));
      put(p, 16'h4e80);
      poll(p + 1, s);
      chk("ram", (32'(p + 1) << 16) | {26'h0, r[7:4] == 4'h0, r[12],
          r[7:4]}, s & 32'h7fff003f);
    end
    // Far jump through the ROM page register.
    put(0, 16'h7123);
    put(15'h1123, 16'h7123);
    go(32'h2, 15'h1123, s);
    chk("far_jmp", 32'h1123, {17'h0, s[30:16]});
    // Call, change acc in the routine, return under three masks.
    for (i = 0; i < 3; i++) begin
      msk = (i == 0) ? 8'h00 : ((i == 1) ? 8'h20 : 8'h5f);
      put(0, 16'hba80);
      put(1, 16'h4e80);
      put(2, 16'h6020);
      put(3, 16'h7003);
      put(32, 16'hbc80);
      put(33, 16'h4e80);
      put(34, {8'h01, msk});
      go(32'h0, 3, s);
      chk("rtn", (i == 1) ? 32'h00030005 : 32'h00030009,
          s & 32'h7fff003f);
    end
    // Table nibbles from RAM, then a look-up through them.
    put(0, 16'hb900);
    put(1, 16'hb881);
    put(2, 16'h8c00);
    put(3, 16'h8c81);
    put(4, 16'h8e81);
    put(5, 16'h8d02);
    put(6, 16'h4e82);
    put(7, 16'h7007);
    put(15'h404, 16'habcd);
    go(32'h0, 7, s);
    chk("lookup", 32'h0007000b, s & 32'h7fff003f);
    xfer(1'b0, A_TAB, 32'h0, s);
    chk("tab", 32'h1012, s & 32'hffff);
    // Indirect store and load in data page 1, cross-read directly.
    put(0, 16'hbb80);
    put(1, 16'he880);
    put(2, 16'hb981);
    put(3, 16'he901);
    put(4, 16'hd882);
    put(5, 16'hc982);
    put(6, 16'h7985);
    put(7, 16'h1813);
    put(8, 16'h7008);
    go(32'h200, 8, s);
    chk("indirect", 32'h0008000e, s & 32'h7fff003f);
    // Enable low freezes the core and the bus; the next opcode waits.
    @(posedge hclk);
    ce <= 1'b0;
    put(8, 16'h1813);
    repeat (4) @(posedge hclk);
    chk("frozen_pc", 32'h8, {17'h0, rom_addr});
    chk("hready_ce", 32'h0, {31'h0, hreadyout});
    ce <= 1'b1;
    poll(9, s);
    chk("ce_resume", 32'h00090015, s & 32'h7fff003f);
    conclude();
  end
endmodule // test_nibble_cpu_instruction_decoder
